//--- design/wd_supervisor.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - temperature supervision disabled means no overtemperature reset and no flag gets set.
// - warning flag follows the warning comparator, clearing itself when it drops.
// - critical flag becoming set while enabled requests a full device reset.
// - critical flag survives the device reset cycle it caused.
// - critical flag cleared only by writing clear bit 1 then 0.
// - reset cause reads 110 for overtemperature, 111 for watchdog.
// - overtemp bits 6 and 7 show raw warning and critical comparators.
// - watchdog runs only while control bit 0 at 2Eh is set.
// - missing trigger either starts a reset or sets the watchdog flag.
// - control bit 1 selects reset on overflow, default 1.
// - control bit 4 picks software bit (0) or selected pin (1).
// - minimum window register at 2Fh counts 16 ms per step.
// - soft trigger bit 0 at 31h drives the trigger level directly.
// - pin with output source 11 carries watchdog flag gated by enable.
module wd_supervisor #(
  parameter int unsigned TICK_CYCLES = wd_supervisor_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_cycle,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] gpio_in,
  input wire logic warn_threshold,
  input wire logic crit_threshold,
  input wire logic [1:0] pin1_output_source,
  input wire logic [1:0] pin2_output_source,
  input wire logic [1:0] pin3_output_source,
  input wire logic wd_int_en,
  input wire logic wd_flag_clear,
  output logic wd_flag,
  output logic [2:0] wd_pin_out,
  output logic reset_request,
  output logic [2:0] reset_cause
);

  localparam int TW = $clog2(TICK_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [2:0] gpio_s;
  logic [1:0] temp_s;
  logic warn_s, crit_s;

  sync_agree #(.WIDTH(3)) u_sync_gpio (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(gpio_in),
    .sync_out(gpio_s)
  );

  sync_agree #(.WIDTH(2)) u_sync_temp (
    .clk(clk),
    .arst_n(arst_n),
    .async_in({crit_threshold, warn_threshold}),
    .sync_out(temp_s)
  );

  assign warn_s = temp_s[0];
  assign crit_s = temp_s[1];

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [4:0] ctrl_q, ctrl_d;
  logic [7:0] wmin_q, wmin_d, wmax_q, wmax_d;
  logic soft_q, soft_d;
  logic ot_en_q, ot_en_d, ot_clr_q, ot_clr_d;
  logic [1:0] ot_test_q, ot_test_d;
  logic warn_q, warn_d, crit_q, crit_d;
  logic [2:0] cause_q, cause_d;
  logic [7:0] rdata_q, rdata_d;
  logic wd_violation;
  logic crit_req;

  // crit flag rising while supervision is on
  assign crit_req = ot_en_q && crit_s && !crit_q;

  always_comb begin
    ctrl_d = ctrl_q;
    wmin_d = wmin_q;
    wmax_d = wmax_q;
    soft_d = soft_q;
    ot_en_d = ot_en_q;
    ot_clr_d = ot_clr_q;
    ot_test_d = ot_test_q;
    cause_d = cause_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      unique case (reg_addr)
        wd_supervisor_pkg::ADDR_WD_CONTROL: ctrl_d = reg_wdata[4:0];
        wd_supervisor_pkg::ADDR_WD_WINDOW_MIN: wmin_d = reg_wdata;
        wd_supervisor_pkg::ADDR_WD_WINDOW_MAX: wmax_d = reg_wdata;
        wd_supervisor_pkg::ADDR_WD_SOFT_TRIGGER: soft_d = reg_wdata[0];
        wd_supervisor_pkg::ADDR_OVERTEMP_CONTROL: begin
          ot_en_d = reg_wdata[wd_supervisor_pkg::OT_ENABLE_BIT];
          ot_clr_d = reg_wdata[wd_supervisor_pkg::OT_CLEAR_BIT];
          // stored as written; the far side keeps them at zero
          ot_test_d = reg_wdata[wd_supervisor_pkg::OT_TEST_B_BIT:wd_supervisor_pkg::OT_TEST_A_BIT];
        end
        default: ;
      endcase
    end
    // warning flag is level-following, meaningless while disabled
    warn_d = ot_en_q && warn_s;
    // set wins over the clear sequence
    crit_d = crit_q;
    if (ot_clr_q && !ot_clr_d) begin
      crit_d = 1'b0;
    end
    if (ot_en_q && crit_s) begin
      crit_d = 1'b1;
    end
    if (crit_req) begin
      cause_d = wd_supervisor_pkg::CAUSE_OVERTEMP;
    end else if (wd_violation && ctrl_q[wd_supervisor_pkg::WD_RESET_ON_BIT]) begin
      cause_d = wd_supervisor_pkg::CAUSE_WATCHDOG;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        wd_supervisor_pkg::ADDR_WD_CONTROL: rdata_d = {3'h0, ctrl_q};
        wd_supervisor_pkg::ADDR_WD_WINDOW_MIN: rdata_d = wmin_q;
        wd_supervisor_pkg::ADDR_WD_WINDOW_MAX: rdata_d = wmax_q;
        wd_supervisor_pkg::ADDR_WD_SOFT_TRIGGER: rdata_d = {7'h00, soft_q};
        wd_supervisor_pkg::ADDR_OVERTEMP_CONTROL: rdata_d = {crit_s, warn_s, ot_test_q, ot_clr_q,
                                                            crit_q, warn_q, ot_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= wd_supervisor_pkg::WD_CONTROL_RESET;
      wmin_q <= wd_supervisor_pkg::WD_WINDOW_MIN_RESET;
      wmax_q <= wd_supervisor_pkg::WD_WINDOW_MAX_RESET;
      soft_q <= 1'b0;
      ot_en_q <= 1'b0;
      ot_clr_q <= 1'b0;
      ot_test_q <= 2'h0;
      warn_q <= 1'b0;
      crit_q <= 1'b0;
      cause_q <= wd_supervisor_pkg::CAUSE_NONE;
      rdata_q <= 8'h00;
    end else if (reset_cycle) begin
      // device reset cycle: defaults, but crit flag and cause are kept
      ctrl_q <= wd_supervisor_pkg::WD_CONTROL_RESET;
      wmin_q <= wd_supervisor_pkg::WD_WINDOW_MIN_RESET;
      wmax_q <= wd_supervisor_pkg::WD_WINDOW_MAX_RESET;
      soft_q <= 1'b0;
      ot_en_q <= 1'b0;
      ot_clr_q <= 1'b0;
      ot_test_q <= 2'h0;
      warn_q <= 1'b0;
      crit_q <= crit_q;
      cause_q <= cause_q;
      rdata_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      wmin_q <= wmin_d;
      wmax_q <= wmax_d;
      soft_q <= soft_d;
      ot_en_q <= ot_en_d;
      ot_clr_q <= ot_clr_d;
      ot_test_q <= ot_test_d;
      warn_q <= warn_d;
      crit_q <= crit_d;
      cause_q <= cause_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watchdog window
  logic [TW-1:0] pre_q, pre_d;
  logic [8:0] elapsed_q, elapsed_d;
  logic trig_q, trig_d, trig_level, trig_rise;
  logic flag_q, flag_d, req_q, req_d;
  logic [2:0] pin_q, pin_d;
  logic wd_on, tick;

  assign wd_on = ctrl_q[wd_supervisor_pkg::WD_ENABLE_BIT];
  assign tick = (pre_q == TW'(TICK_CYCLES - 1));

  always_comb begin
    // selector 11 is unused; it falls back to pin three
    unique case (ctrl_q[wd_supervisor_pkg::WD_PIN_SEL_LSB+:2])
      2'h0: trig_level = gpio_s[0];
      2'h1: trig_level = gpio_s[1];
      default: trig_level = gpio_s[2];
    endcase
    if (!ctrl_q[wd_supervisor_pkg::WD_TRIG_SRC_BIT]) begin
      trig_level = soft_q;
    end
  end

  assign trig_rise = trig_level && !trig_q;
  // early trigger or window timeout; a max register written to zero times out at once
  assign wd_violation = wd_on && ((trig_rise && (elapsed_q < {1'b0, wmin_q}))
                        || (!trig_rise && (elapsed_q >= {1'b0, wmax_q})));

  always_comb begin
    trig_d = trig_level;
    pre_d = tick ? '0 : pre_q + TW'(1);
    elapsed_d = elapsed_q;
    if (tick && (elapsed_q != 9'h1FF)) begin
      elapsed_d = elapsed_q + 9'h001;
    end
    if (!wd_on || trig_rise || wd_violation) begin
      pre_d = '0;
      elapsed_d = 9'h000;
    end
    flag_d = flag_q;
    if (wd_flag_clear) begin
      flag_d = 1'b0;
    end
    if (wd_violation && !ctrl_q[wd_supervisor_pkg::WD_RESET_ON_BIT]) begin
      flag_d = 1'b1;
    end
    req_d = crit_req || (wd_violation && ctrl_q[wd_supervisor_pkg::WD_RESET_ON_BIT]);
    pin_d[0] = (pin1_output_source == wd_supervisor_pkg::PIN_SRC_WATCHDOG) && flag_d && wd_int_en;
    pin_d[1] = (pin2_output_source == wd_supervisor_pkg::PIN_SRC_WATCHDOG) && flag_d && wd_int_en;
    pin_d[2] = (pin3_output_source == wd_supervisor_pkg::PIN_SRC_WATCHDOG) && flag_d && wd_int_en;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= '0;
      elapsed_q <= 9'h000;
      trig_q <= 1'b0;
      flag_q <= 1'b0;
      req_q <= 1'b0;
      pin_q <= 3'h0;
    end else if (reset_cycle) begin
      pre_q <= '0;
      elapsed_q <= 9'h000;
      trig_q <= 1'b0;
      flag_q <= 1'b0;
      req_q <= 1'b0;
      pin_q <= 3'h0;
    end else begin
      pre_q <= pre_d;
      elapsed_q <= elapsed_d;
      trig_q <= trig_d;
      flag_q <= flag_d;
      req_q <= req_d;
      pin_q <= pin_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign wd_flag = flag_q;
  assign wd_pin_out = pin_q;
  assign reset_request = req_q;
  assign reset_cause = cause_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n || reset_cycle);

  no_ot_reset_a: assert property (!ot_en_q && !wd_violation |=> !reset_request && !warn_q)
    else $error("overtemperature reset while supervision off");
  warn_follow_a: assert property (ot_en_q && $stable(ot_en_q) |=> warn_q == $past(warn_s))
    else $error("warning flag does not follow comparator");
  crit_reset_a: assert property (crit_req |=> reset_request && reset_cause == 3'h6)
    else $error("critical flag did not request reset");
  crit_keep_a: assert property (@(posedge clk) disable iff (!arst_n)
    crit_q && !(ot_clr_q && !ot_clr_d) |=> crit_q)
    else $error("critical flag lost without clear sequence");
  crit_clear_a: assert property (crit_q && ot_clr_q && !ot_clr_d && !(ot_en_q && crit_s) |=> !crit_q)
    else $error("clear sequence did not clear critical flag");
  wd_cause_a: assert property (wd_violation && ctrl_q[1] && !crit_req |=> reset_cause == 3'h7)
    else $error("watchdog reset cause wrong");
  wd_off_a: assert property (!wd_on |=> !$rose(wd_flag) && elapsed_q == 9'h000)
    else $error("watchdog acted while disabled");
  wd_irq_a: assert property (wd_violation && !ctrl_q[1] && !crit_req |=> wd_flag && !reset_request)
    else $error("interrupt action wrong");
  wd_early_a: assert property (wd_on && trig_rise && elapsed_q < {1'b0, wmin_q} |=> wd_flag || reset_request)
    else $error("early trigger not flagged");
  wd_pin_a: assert property (pin2_output_source == 2'h3 && wd_int_en ##1 wd_flag |-> wd_pin_out[1])
    else $error("watchdog pin output missing");

  wd_reset_c: cover property (wd_violation && ctrl_q[1]);
  wd_retrig_c: cover property (wd_on && trig_rise && !wd_violation);
  crit_clear_c: cover property (crit_q ##1 !crit_q);

endmodule

`default_nettype wire

//--- design/wd_supervisor_pkg.sv
`default_nettype none

package wd_supervisor_pkg;

  // register map
  localparam logic [7:0] ADDR_WD_CONTROL = 8'h2E;
  localparam logic [7:0] ADDR_WD_WINDOW_MIN = 8'h2F;
  localparam logic [7:0] ADDR_WD_WINDOW_MAX = 8'h30;
  localparam logic [7:0] ADDR_WD_SOFT_TRIGGER = 8'h31;
  localparam logic [7:0] ADDR_OVERTEMP_CONTROL = 8'h3B;

  // watchdog_control fields
  localparam int WD_ENABLE_BIT = 0;
  localparam int WD_RESET_ON_BIT = 1;
  localparam int WD_PIN_SEL_LSB = 2;
  localparam int WD_TRIG_SRC_BIT = 4;
  localparam logic [4:0] WD_CONTROL_RESET = 5'h02;

  // overtemp_control fields
  localparam int OT_ENABLE_BIT = 0;
  localparam int OT_WARN_BIT = 1;
  localparam int OT_CRIT_BIT = 2;
  localparam int OT_CLEAR_BIT = 3;
  localparam int OT_TEST_A_BIT = 4;
  localparam int OT_TEST_B_BIT = 5;
  localparam int OT_WARN_RAW_BIT = 6;
  localparam int OT_CRIT_RAW_BIT = 7;

  localparam logic [7:0] WD_WINDOW_MIN_RESET = 8'h00;
  localparam logic [7:0] WD_WINDOW_MAX_RESET = 8'hFF;

  // reset cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_OVERTEMP = 3'h6;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h7;

  // pin output source code that routes the watchdog output
  localparam logic [1:0] PIN_SRC_WATCHDOG = 2'h3;

  // window tick timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 16;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

endpackage

`default_nettype wire

//--- design/sync_agree.sv
`timescale 1ns/100ps
`default_nettype none

// three-stage synchroniser: output follows once stages two and three agree
module sync_agree #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q, out_d;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule

`default_nettype wire

//--- verification/host_keepalive.sv
`timescale 1ns/100ps
`default_nettype none

// host side: one rising edge every period cycles on the chosen pin
module host_keepalive (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic on,
  input wire logic [1:0] pin,
  input wire logic [7:0] period,
  output logic [2:0] trig_pins
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) cnt_q <= 8'h00;
    else if (!on || cnt_q >= period - 8'h01) cnt_q <= 8'h00;
    else cnt_q <= cnt_q + 8'h01;
  end

  // other pins driven low, never floated; selector 11 never used
  always_comb begin
    trig_pins = 3'h0;
    trig_pins[pin] = on && (cnt_q < {1'b0, period[7:1]});
  end
endmodule

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk, arst_n, reset_cycle, reg_wr, reg_rd, warn_t, crit_t, int_en, flag_clr, h_on, wd_flag, rst_req;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, h_period;
  logic [2:0] gpio, wd_pin, cause;
  logic [1:0] src1, src2, src3, h_pin;
  int n_mismatch = 0;
  int checked = 0;
  int n_req = 0;

  // short tick keeps window runs to tens of cycles
  wd_supervisor #(.TICK_CYCLES(8)) dut_u (.clk(clk), .arst_n(arst_n), .reset_cycle(reset_cycle),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .gpio_in(gpio), .warn_threshold(warn_t), .crit_threshold(crit_t), .pin1_output_source(src1),
    .pin2_output_source(src2), .pin3_output_source(src3), .wd_int_en(int_en), .wd_flag_clear(flag_clr),
    .wd_flag(wd_flag), .wd_pin_out(wd_pin), .reset_request(rst_req), .reset_cause(cause));
  host_keepalive host_u (.clk(clk), .arst_n(arst_n), .on(h_on), .pin(h_pin), .period(h_period),
    .trig_pins(gpio));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // one-cycle pulse: counted here so no check can miss it
  always @(posedge clk) if (rst_req === 1'b1) n_req++;

  ////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    cyc(1);
    cmp(reg_rdata, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////
  task automatic t_defaults;
    rd(8'h2E, 8'h02);
    rd(8'h2F, 8'h00);
    rd(8'h30, 8'hFF);
    rd(8'h31, 8'h00);
    rd(8'h3B, 8'h00);
    rd(8'h50, 8'h00);
    cmp({5'h0, cause}, 8'h00);
    $display("test defaults done");
  endtask
  task automatic t_thermal;
    int r0;
    r0 = n_req;
    crit_t = 1'b1;
    cyc(12);
    cmp(8'(n_req - r0), 8'h00);
    crit_t = 1'b0;
    // let the synchronised comparator drop before enabling, or enable sees a stale crit
    cyc(8);
    wr(8'h3B, 8'h01);
    cyc(8);
    warn_t = 1'b1;
    cyc(8);
    rd(8'h3B, 8'h43);
    warn_t = 1'b0;
    cyc(8);
    rd(8'h3B, 8'h01);
    crit_t = 1'b1;
    cyc(10);
    cmp(8'(n_req - r0), 8'h01);
    cmp({5'h0, cause}, 8'h06);
    rd(8'h3B, 8'h85);
    crit_t = 1'b0;
    cyc(8);
    reset_cycle = 1'b1;
    cyc(1);
    reset_cycle = 1'b0;
    cyc(1);
    rd(8'h3B, 8'h04);
    cmp({5'h0, cause}, 8'h06);
    wr(8'h3B, 8'h08);
    wr(8'h3B, 8'h00);
    rd(8'h3B, 8'h00);
    $display("test thermal done");
  endtask
  task automatic t_soft;
    int r0;
    wr(8'h30, 8'h02);
    wr(8'h2E, 8'h01);
    repeat (10) begin
      wr(8'h31, 8'h01);
      cyc(2);
      wr(8'h31, 8'h00);
      cyc(2);
    end
    cmp({7'h0, wd_flag}, 8'h00);
    cyc(40);
    cmp({7'h0, wd_flag}, 8'h01);
    wr(8'h2E, 8'h00);
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    cyc(40);
    cmp({7'h0, wd_flag}, 8'h00);
    r0 = n_req;
    wr(8'h2E, 8'h03);
    cyc(24);
    wr(8'h2E, 8'h00);
    cmp(8'(n_req - r0), 8'h01);
    cmp({5'h0, cause}, 8'h07);
    cmp({7'h0, wd_flag}, 8'h00);
    $display("test soft trigger done");
  endtask
  task automatic t_pins;
    wr(8'h30, 8'h03);
    h_on = 1'b1;
    int_en = 1'b1;
    src2 = 2'h3;
    for (int p = 0; p < 3; p++) begin
      h_pin = 2'(p);
      wr(8'h2E, {3'h0, 1'b1, 2'(p), 2'b01});
      cyc(150);
      cmp({7'h0, wd_flag}, 8'h00);
      wr(8'h2E, 8'h00);
    end
    wr(8'h2F, 8'h02);
    h_period = 8'd8;
    h_pin = 2'h1;
    wr(8'h2E, 8'h15);
    cyc(30);
    cmp({7'h0, wd_flag}, 8'h01);
    cmp({5'h0, wd_pin}, 8'h02);
    int_en = 1'b0;
    cyc(2);
    cmp({5'h0, wd_pin}, 8'h00);
    int_en = 1'b1;
    wr(8'h2E, 8'h00);
    h_on = 1'b0;
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    cyc(2);
    cmp({5'h0, wd_pin}, 8'h00);
    $display("test pin trigger done");
  endtask

  ////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    reset_cycle = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    warn_t = 1'b0;
    crit_t = 1'b0;
    src1 = 2'h0;
    src2 = 2'h0;
    src3 = 2'h0;
    int_en = 1'b0;
    flag_clr = 1'b0;
    h_on = 1'b0;
    h_pin = 2'h0;
    h_period = 8'd12;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    cyc(1);
    t_defaults;
    t_thermal;
    t_soft;
    t_pins;
    print_verdict;
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule

`default_nettype wire
